/* rtl/key_lockout.sv */
// Access-key lockout manager: command gate, key checks, credentials
`timescale 1ns/1ps
`default_nettype none
module key_lockout
  import key_lockout_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = BLOCK_WAIT_S * CLK_HZ,
  parameter logic [KEY_W-1:0] UNBLOCK_KEY = 32'h1234_5678,
  parameter logic [KEY_W-1:0] MASTER_KEY  = 32'h8765_4321,
  parameter logic [KEY_W-1:0] PROV_KEY    = 32'h0bad_cafe
)(
  // Clock, reset, enable
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Command in
  input  wire logic              cmd_valid,
  input  wire cmd_t              cmd,
  output logic                   cmd_ready,
  // Response out
  output logic                   rsp_valid,
  output rsp_t                   rsp,
  // Network registration result
  input  wire logic              net_ok,
  input  wire logic [CRED_W-1:0] net_cred,
  input  wire logic              net_encrypt,
  // Status
  output logic                   code_required,
  output logic                   code_blocked,
  output logic                   unblk_blocked,
  output logic                   prov_blocked,
  output logic                   prov_mode,
  output logic                   net_access,
  output logic                   encrypt_on,
  output logic                   cfg_we,
  output logic [KEY_W-1:0]       cfg_data,
  output logic [SLOT_W-1:0]      active_slot
);

  fsm_t              state_q;
  cmd_t              cmd_q;
  logic [31:0]       wait_q;
  logic [KEY_W-1:0]  code_q;
  logic              code_req_q;
  logic              code_ok_q;
  logic              code_temp_q;
  logic              prov_ok_q;
  logic              prov_temp_q;
  rsp_code_t         res_d;
  logic              code_bad, code_good, unblk_bad, unblk_good;
  logic              prov_bad, prov_good, clr_blk;
  logic              cred_we;
  logic [CRED_W-1:0] cred_wd, cred_rd;
  logic [3:0]        code_cnt, unblk_cnt, prov_cnt;
  logic              code_blk_w, unblk_blk_w, prov_blk_w;

  wire exec = ce && state_q == ST_EXEC;
  // Provider mode has no off switch beyond a wrong provider key and a block clear
  wire prov_in = prov_ok_q || prov_temp_q;

  fail_counter u_code_cnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .limit   (CODE_FAIL_MAX),
    .bad     (code_bad),
    .good    (code_good),
    .clear   (clr_blk),
    .blocked (code_blk_w),
    .count   (code_cnt)
  );

  fail_counter u_unblk_cnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .limit   (UNBLK_FAIL_MAX),
    .bad     (unblk_bad),
    .good    (unblk_good),
    .clear   (clr_blk),
    .blocked (unblk_blk_w),
    .count   (unblk_cnt)
  );

  fail_counter u_prov_cnt (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .limit   (PROV_FAIL_MAX),
    .bad     (prov_bad),
    .good    (prov_good),
    .clear   (clr_blk),
    .blocked (prov_blk_w),
    .count   (prov_cnt)
  );

  cred_store u_cred (
    .clk     (clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .wr_en   (cred_we),
    .wr_slot (active_slot),
    .wr_data (cred_wd),
    .rd_slot (active_slot),
    .rd_data (cred_rd)
  );

  // Decode of the held command in the execute state
  always_comb begin
    res_d      = RSP_OK;
    code_bad   = 1'b0;
    code_good  = 1'b0;
    unblk_bad  = 1'b0;
    unblk_good = 1'b0;
    prov_bad   = 1'b0;
    prov_good  = 1'b0;
    clr_blk    = 1'b0;
    if (exec) begin
      case (cmd_q.op)
        CMD_CODE_ENABLE: begin
          if (code_blk_w && !code_temp_q) begin
            res_d = RSP_BLOCKED;
          end else if (cmd_q.key == code_q) begin
            code_good = 1'b1;
          end else begin
            code_bad = 1'b1;
            res_d    = RSP_BADKEY;
          end
        end
        CMD_REGISTER, CMD_DIAL: begin
          if (code_req_q && !code_ok_q) begin
            res_d = RSP_DENIED;
          end
        end
        CMD_UNBLOCK: begin
          if (unblk_blk_w) begin
            res_d = RSP_BLOCKED;
          end else if (cmd_q.key == UNBLOCK_KEY) begin
            unblk_good = 1'b1;
          end else begin
            unblk_bad = 1'b1;
            res_d     = RSP_BADKEY;
          end
        end
        CMD_CLEAR_BLOCK, CMD_CFG_WRITE, CMD_ADDR_LOAD: begin
          if (!prov_in) begin
            res_d = RSP_DENIED;
          end else if (cmd_q.op == CMD_CLEAR_BLOCK) begin
            clr_blk = 1'b1;
          end
        end
        CMD_SET_CODE, CMD_CODE_REQ: begin
          if (!prov_in && !code_temp_q && !code_ok_q) begin
            res_d = RSP_DENIED;
          end
        end
        CMD_PROV_KEY: begin
          if (prov_blk_w) begin
            // Master key is compared but never counted
            res_d = (cmd_q.key == MASTER_KEY) ? RSP_OK : RSP_BLOCKED;
          end else if (cmd_q.key == PROV_KEY) begin
            prov_good = 1'b1;
          end else begin
            prov_bad = 1'b1;
            res_d    = RSP_BADKEY;
          end
        end
        CMD_REG_DONE: res_d = RSP_OK;
        default:      res_d = RSP_ERROR;
      endcase
    end
  end

  // Command sequencer
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      cmd_q     <= '0;
      wait_q    <= 32'h0;
      cmd_ready <= 1'b1;
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else if (ce) begin
      rsp_valid <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_q     <= cmd;
            cmd_ready <= 1'b0;
            state_q   <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          rsp.code <= res_d;
          rsp.cred <= cred_rd;
          // Slow answer stalls brute-force search for the master key
          if (res_d == RSP_BLOCKED && cmd_q.op == CMD_PROV_KEY) begin
            wait_q  <= WAIT_CYCLES - 32'h1;
            state_q <= ST_WAIT;
          end else begin
            state_q <= ST_RESP;
          end
        end
        ST_WAIT: begin
          if (wait_q == 32'h0) begin
            state_q <= ST_RESP;
          end else begin
            wait_q <= wait_q - 32'h1;
          end
        end
        ST_RESP: begin
          rsp_valid <= 1'b1;
          cmd_ready <= 1'b1;
          state_q   <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Personal code state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_q      <= CODE_RESET;
      code_req_q  <= 1'b0;
      code_ok_q   <= 1'b0;
      code_temp_q <= 1'b0;
    end else if (exec && res_d == RSP_OK) begin
      case (cmd_q.op)
        CMD_CODE_ENABLE: code_ok_q <= 1'b1;
        CMD_UNBLOCK:     code_temp_q <= 1'b1;
        CMD_SET_CODE: begin
          code_q      <= cmd_q.arg;
          code_temp_q <= 1'b0;
        end
        CMD_CODE_REQ: begin
          code_req_q <= cmd_q.flag;
          code_ok_q  <= 1'b0;
        end
        CMD_CLEAR_BLOCK: code_temp_q <= 1'b0;
        default:         code_ok_q <= code_ok_q;
      endcase
    end
  end

  // Provider key state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prov_ok_q   <= 1'b0;
      prov_temp_q <= 1'b0;
    end else if (exec) begin
      if (prov_good) begin
        prov_ok_q <= 1'b1;
      end else if (prov_bad) begin
        prov_ok_q <= 1'b0;
      end
      if (cmd_q.op == CMD_PROV_KEY && prov_blk_w && res_d == RSP_OK) begin
        prov_temp_q <= 1'b1;
      end else if (clr_blk) begin
        prov_temp_q <= 1'b0;
      end
    end
  end

  // Credentials, configuration and encryption
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cred_we     <= 1'b0;
      cred_wd     <= CRED_ZERO;
      cfg_we      <= 1'b0;
      cfg_data    <= '0;
      active_slot <= '0;
      encrypt_on  <= 1'b0;
    end else if (ce) begin
      cred_we <= 1'b0;
      cfg_we  <= 1'b0;
      if (exec && res_d == RSP_OK) begin
        if (cmd_q.op == CMD_ADDR_LOAD) begin
          active_slot <= cmd_q.slot;
          cred_we     <= 1'b1;
          cred_wd     <= CRED_ZERO;
        end else if (cmd_q.op == CMD_CFG_WRITE) begin
          cfg_we   <= 1'b1;
          cfg_data <= cmd_q.arg;
        end else if (cmd_q.op == CMD_REG_DONE && net_ok) begin
          cred_we    <= 1'b1;
          cred_wd    <= net_cred;
          encrypt_on <= net_encrypt;
        end
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      code_required <= 1'b0;
      code_blocked  <= 1'b0;
      unblk_blocked <= 1'b0;
      prov_blocked  <= 1'b0;
      prov_mode     <= 1'b0;
      net_access    <= 1'b1;
    end else if (ce) begin
      code_required <= code_req_q;
      code_blocked  <= code_blk_w;
      unblk_blocked <= unblk_blk_w;
      prov_blocked  <= prov_blk_w;
      prov_mode     <= prov_in;
      net_access    <= !code_req_q || code_ok_q;
    end
  end

endmodule : key_lockout
`default_nettype wire

/* rtl/key_lockout_pkg.sv */
// Shared constants and types for the access-key lockout manager
package key_lockout_pkg;

  localparam int unsigned KEY_W          = 32;
  localparam int unsigned CRED_W         = 32;
  localparam int unsigned ADDR_W         = 32;
  localparam int unsigned SLOT_W         = 2;
  localparam int unsigned SLOTS          = 4;
  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned BLOCK_WAIT_S   = 30;
  localparam logic [3:0]  CODE_FAIL_MAX  = 4'h3;
  localparam logic [3:0]  UNBLK_FAIL_MAX = 4'ha;
  localparam logic [3:0]  PROV_FAIL_MAX  = 4'h3;
  localparam logic [KEY_W-1:0]  CODE_RESET  = 32'h0000_0000;
  localparam logic [CRED_W-1:0] CRED_ZERO   = 32'h0000_0000;

  // Command opcodes
  typedef enum logic [3:0] {
    CMD_CODE_ENABLE = 4'h0,
    CMD_REGISTER    = 4'h1,
    CMD_DIAL        = 4'h2,
    CMD_UNBLOCK     = 4'h3,
    CMD_CLEAR_BLOCK = 4'h4,
    CMD_SET_CODE    = 4'h5,
    CMD_PROV_KEY    = 4'h6,
    CMD_CFG_WRITE   = 4'h7,
    CMD_ADDR_LOAD   = 4'h8,
    CMD_CODE_REQ    = 4'h9,
    CMD_REG_DONE    = 4'ha
  } cmd_op_t;

  typedef enum logic [2:0] {
    RSP_OK      = 3'h0,
    RSP_ERROR   = 3'h1,
    RSP_BLOCKED = 3'h2,
    RSP_DENIED  = 3'h3,
    RSP_BADKEY  = 3'h4
  } rsp_code_t;

  typedef struct packed {
    cmd_op_t             op;
    logic [KEY_W-1:0]    key;
    logic [KEY_W-1:0]    arg;
    logic [SLOT_W-1:0]   slot;
    logic                flag;
  } cmd_t;

  typedef struct packed {
    rsp_code_t           code;
    logic [CRED_W-1:0]   cred;
  } rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_WAIT = 2'b11,
    ST_RESP = 2'b10
  } fsm_t;

endpackage : key_lockout_pkg

/* rtl/cred_store.sv */
// Per-slot credential memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module cred_store
  import key_lockout_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              ce,
  // Write port
  input  wire logic              wr_en,
  input  wire logic [SLOT_W-1:0] wr_slot,
  input  wire logic [CRED_W-1:0] wr_data,
  // Read port
  input  wire logic [SLOT_W-1:0] rd_slot,
  output logic      [CRED_W-1:0] rd_data
);

  logic [CRED_W-1:0] mem_q [SLOTS];

  for (genvar i = 0; i < SLOTS; i++) begin : g_slot
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        mem_q[i] <= CRED_ZERO;
      end else if (ce && wr_en && wr_slot == SLOT_W'(i)) begin
        mem_q[i] <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= CRED_ZERO;
    end else if (ce) begin
      rd_data <= mem_q[rd_slot];
    end
  end

endmodule : cred_store
`default_nettype wire

/* rtl/fail_counter.sv */
// Consecutive-failure counter with sticky block flag
`timescale 1ns/1ps
`default_nettype none
module fail_counter
  import key_lockout_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Control
  input  wire logic [3:0] limit,
  input  wire logic       bad,
  input  wire logic       good,
  input  wire logic       clear,
  // Status
  output logic            blocked,
  output logic [3:0]      count
);

  // Failure wins over clear so a late wrong entry is never lost
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count   <= 4'h0;
      blocked <= 1'b0;
    end else if (ce) begin
      if (bad) begin
        if (count + 4'h1 >= limit) begin
          blocked <= 1'b1;
          count   <= 4'h0;
        end else begin
          count <= count + 4'h1;
        end
      end else if (good || clear) begin
        count <= 4'h0;
        if (clear) begin
          blocked <= 1'b0;
        end
      end
    end
  end

endmodule : fail_counter
`default_nettype wire

/* dv/key_lockout_monitor.sv */
// Port-level assertion checker for the lockout manager
`timescale 1ns/1ps
`default_nettype none
module key_lockout_monitor
  import key_lockout_pkg::*;
#(
  parameter int unsigned      WAIT_CYCLES = 10,
  parameter logic [KEY_W-1:0] MASTER_KEY  = 32'h0000_0000
)(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Command and answer
  input wire logic cmd_valid,
  input wire cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire rsp_t rsp,
  // Status
  input wire logic code_blocked,
  input wire logic unblk_blocked,
  input wire logic prov_blocked,
  input wire logic prov_mode,
  input wire logic net_access,
  input wire logic encrypt_on,
  input wire logic cfg_we
);
  logic        take;
  logic        slow_q;
  logic        mst_q;
  logic        pm_q;
  cmd_op_t     op_q;
  int unsigned cnt_q;

  assign take = ce && cmd_valid && cmd_ready;

  // Facts about the command in flight
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_q   <= CMD_CODE_ENABLE;
      slow_q <= 1'b0;
      mst_q  <= 1'b0;
      pm_q   <= 1'b0;
    end else if (take) begin
      op_q   <= cmd.op;
      slow_q <= cmd.op == CMD_PROV_KEY && prov_blocked && cmd.key != MASTER_KEY;
      mst_q  <= cmd.op == CMD_PROV_KEY && prov_blocked && cmd.key == MASTER_KEY;
      pm_q   <= prov_mode;
    end
  end

  // Cycles since the command was taken; too long for a repetition
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 0;
    end else if (take) begin
      cnt_q <= 1;
    end else if (ce && cnt_q != 0 && !rsp_valid) begin
      cnt_q <= cnt_q + 1;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ans_time_a: assert property (rsp_valid |-> cnt_q == (slow_q ? WAIT_CYCLES + 3 : 3))
    else $error("answer latency wrong");
  slow_blk_a: assert property (rsp_valid && slow_q |-> rsp.code == RSP_BLOCKED)
    else $error("delayed answer not blocked");
  master_ok_a: assert property (rsp_valid && mst_q |-> rsp.code == RSP_OK ##[0:2] prov_mode)
    else $error("master key not honoured");
  cfg_gate_a: assert property (cfg_we |-> prov_mode)
    else $error("config write outside provider mode");
  prov_only_a: assert property (rsp_valid && rsp.code == RSP_OK &&
      op_q inside {CMD_CLEAR_BLOCK, CMD_CFG_WRITE, CMD_ADDR_LOAD} |-> pm_q)
    else $error("protected command ran without provider mode");
  net_gate_a: assert property (rsp_valid && rsp.code == RSP_OK &&
      op_q inside {CMD_REGISTER, CMD_DIAL} |-> net_access)
    else $error("network command ran without access");
  code_blk_a: assert property ($rose(code_blocked) |-> op_q == CMD_CODE_ENABLE)
    else $error("code blocked by wrong command");
  code_clr_a: assert property ($fell(code_blocked) |-> op_q == CMD_CLEAR_BLOCK)
    else $error("code block cleared by wrong command");
  unblk_clr_a: assert property ($fell(unblk_blocked) |-> op_q == CMD_CLEAR_BLOCK)
    else $error("unblock key block cleared by wrong command");
  prov_blk_a: assert property ($rose(prov_blocked) |-> op_q == CMD_PROV_KEY)
    else $error("provider key blocked by wrong command");
  enc_src_a: assert property ($changed(encrypt_on) |-> op_q == CMD_REG_DONE)
    else $error("encryption changed outside negotiation");
endmodule : key_lockout_monitor
`default_nettype wire

/* dv/host_model.sv */
// Host terminal model offering one command at a time
`timescale 1ns/1ps
`default_nettype none
module host_model
  import key_lockout_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Command out
  output var logic  cmd_valid,
  output var cmd_t  cmd,
  input  wire logic cmd_ready
);
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end

  // Request held until ready is seen at an edge
  task automatic send(input cmd_t c);
    int   n;
    logic rdy;
    n = 0;
    @(posedge clk);
    #2;
    cmd = c;
    cmd_valid = 1'b1;
    // Ready read while settled, so it is the value the edge will take
    do begin
      rdy = cmd_ready;
      @(posedge clk);
      n++;
    end while (rdy !== 1'b1 && n < 50);
    #2;
    cmd_valid = 1'b0;
    // Released lines carry the inverse of the last command, never the command itself
    cmd = cmd_t'(~c);
  endtask : send
endmodule : host_model
`default_nettype wire

/* dv/key_lockout_tb.sv */
// Self-checking bench for the lockout manager
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %h got %h", n, e, g); end end
module key_lockout_tb;
  import key_lockout_pkg::*;
  localparam logic [31:0] UK = 32'h0000_1111; // arbitrary
  localparam logic [31:0] MK = 32'h0000_2222; // arbitrary
  localparam logic [31:0] PK = 32'h0000_3333; // arbitrary
  localparam int LIMIT = 5000; // About fifteen times the expected run
  logic clk, rst_n, ce, cmd_valid, cmd_ready, rsp_valid, net_ok, net_encrypt;
  logic code_required, code_blocked, unblk_blocked, prov_blocked, prov_mode;
  logic net_access, encrypt_on, cfg_we;
  logic [31:0] net_cred, cfg_data, cfg_seen, nc;
  logic [1:0]  active_slot;
  logic [35:0] e;
  logic [35:0] exp_q[$];
  cmd_t        cmd;
  rsp_t        rsp;
  int          mismatches, n_tests;

  key_lockout #(.WAIT_CYCLES(10), .UNBLOCK_KEY(UK), .MASTER_KEY(MK), .PROV_KEY(PK)) uut (
    .clk, .rst_n, .ce, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp, .net_ok,
    .net_cred, .net_encrypt, .code_required, .code_blocked, .unblk_blocked,
    .prov_blocked, .prov_mode, .net_access, .encrypt_on, .cfg_we, .cfg_data, .active_slot);
  host_model hm (.clk, .cmd_valid, .cmd, .cmd_ready);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  function automatic logic [31:0] bad(input logic [31:0] k);
    logic [31:0] r;
    r = $urandom;
    return (r == k) ? ~k : r;
  endfunction : bad

  // Note the answer, send, then wait out the answer and status update
  task automatic run(input cmd_op_t op, input logic [31:0] key, input rsp_code_t code,
                     input logic [31:0] cred = 32'h0, input logic chk = 1'b0,
                     input logic [1:0] slot = 2'h0, input logic flag = 1'b0);
    int n;
    exp_q.push_back({chk, code, cred});
    hm.send('{op, key, key, slot, flag});
    n = 0;
    do begin
      @(posedge clk);
      #2;
      n++;
    end while (rsp_valid !== 1'b1 && n < 100);
    @(posedge clk);
    #2;
  endtask : run

  always @(negedge clk) begin
    if (cfg_we === 1'b1) cfg_seen <= cfg_data;
  end

  // Falling edge keeps the look away from the launching edge
  always @(negedge clk) begin
    if (rst_n && rsp_valid === 1'b1) begin
      e = exp_q.pop_front();
      `CHK("code", e[34:32], rsp.code)
      if (e[35]) `CHK("cred", e[31:0], rsp.cred)
    end
  end

  initial begin
    repeat (LIMIT) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(32'h84d7));
    {rst_n, ce, net_ok, net_encrypt, net_cred} = {1'b0, 1'b1, 1'b0, 1'b0, 32'h0};
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    `CHK("req", 1'b0, code_required)
    `CHK("acc", 1'b1, net_access)
    run(CMD_CFG_WRITE, 32'h0, RSP_DENIED);
    run(CMD_CLEAR_BLOCK, 32'h0, RSP_DENIED);
    run(CMD_ADDR_LOAD, 32'h0, RSP_DENIED);
    repeat (2) run(CMD_PROV_KEY, bad(PK), RSP_BADKEY);
    run(CMD_PROV_KEY, PK, RSP_OK);
    run(CMD_CFG_WRITE, 32'h0000_00a5, RSP_OK);
    `CHK("cfg", 32'h0000_00a5, cfg_seen)
    run(CMD_CODE_REQ, 32'h0, RSP_OK, 32'h0, 1'b0, 2'h0, 1'b1);
    `CHK("req", 1'b1, code_required)
    `CHK("acc", 1'b0, net_access)
    run(CMD_REGISTER, 32'h0, RSP_DENIED);
    run(CMD_DIAL, 32'h0, RSP_DENIED);
    repeat (3) run(CMD_CODE_ENABLE, bad(CODE_RESET), RSP_BADKEY);
    `CHK("cblk", 1'b1, code_blocked)
    run(CMD_CODE_ENABLE, CODE_RESET, RSP_BLOCKED);
    run(CMD_UNBLOCK, UK, RSP_OK);
    run(CMD_CODE_ENABLE, CODE_RESET, RSP_OK);
    `CHK("cblk", 1'b1, code_blocked)
    repeat (9) run(CMD_UNBLOCK, bad(UK), RSP_BADKEY);
    `CHK("ublk", 1'b0, unblk_blocked)
    run(CMD_UNBLOCK, bad(UK), RSP_BADKEY);
    `CHK("ublk", 1'b1, unblk_blocked)
    run(CMD_UNBLOCK, UK, RSP_BLOCKED);
    run(CMD_CLEAR_BLOCK, 32'h0, RSP_OK);
    `CHK("both", 2'b00, {code_blocked, unblk_blocked})
    nc = bad(CODE_RESET);
    run(CMD_SET_CODE, nc, RSP_OK);
    run(CMD_CODE_ENABLE, CODE_RESET, RSP_BADKEY);
    run(CMD_CODE_ENABLE, nc, RSP_OK);
    `CHK("acc", 1'b1, net_access)
    run(CMD_REGISTER, 32'h0, RSP_OK);
    {net_ok, net_encrypt, net_cred} = {1'b1, 1'b1, $urandom};
    run(CMD_REG_DONE, 32'h0, RSP_OK);
    `CHK("enc", 1'b1, encrypt_on)
    run(CMD_DIAL, 32'h0, RSP_OK, net_cred, 1'b1);
    net_encrypt = 1'b0;
    run(CMD_REG_DONE, 32'h0, RSP_OK);
    `CHK("enc", 1'b0, encrypt_on)
    run(CMD_ADDR_LOAD, 32'h0, RSP_OK, 32'h0, 1'b0, active_slot);
    run(CMD_DIAL, 32'h0, RSP_OK, CRED_ZERO, 1'b1);
    run(CMD_ADDR_LOAD, 32'h0, RSP_OK, 32'h0, 1'b0, 2'h2);
    `CHK("slot", 2'h2, active_slot)
    repeat (2) run(CMD_PROV_KEY, bad(PK), RSP_BADKEY);
    `CHK("pblk", 1'b0, prov_blocked)
    run(CMD_PROV_KEY, bad(PK), RSP_BADKEY);
    `CHK("pblk", 1'b1, prov_blocked)
    run(CMD_PROV_KEY, PK, RSP_BLOCKED);
    repeat (3) run(CMD_PROV_KEY, bad(MK), RSP_BLOCKED);
    // Enable dropped inside the slow wait; the answer must slip by as much
    fork
      begin
        repeat (8) @(posedge clk);
        #2 ce = 1'b0;
        repeat (5) @(posedge clk);
        #2 ce = 1'b1;
      end
    join_none
    run(CMD_PROV_KEY, bad(MK), RSP_BLOCKED);
    run(CMD_PROV_KEY, MK, RSP_OK);
    `CHK("pm", 1'b1, prov_mode)
    run(CMD_CLEAR_BLOCK, 32'h0, RSP_OK);
    `CHK("pblk", 1'b0, prov_blocked)
    run(CMD_PROV_KEY, PK, RSP_OK);
    `CHK("pm", 1'b1, prov_mode)
    @(posedge clk);
    #2 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #2 rst_n = 1'b1;
    `CHK("pm", 1'b0, prov_mode)
    `CHK("req", 1'b0, code_required)
    close_out();
  end
endmodule : key_lockout_tb

bind key_lockout key_lockout_monitor #(.WAIT_CYCLES(WAIT_CYCLES), .MASTER_KEY(MASTER_KEY)) mon (
  .clk, .rst_n, .ce, .cmd_valid, .cmd, .cmd_ready, .rsp_valid, .rsp, .code_blocked,
  .unblk_blocked, .prov_blocked, .prov_mode, .net_access, .encrypt_on, .cfg_we);
`default_nettype wire
